//--- src/exc_entry_unit.sv
// exception entry sequencer: arbitration, link and status save, mode and vector
// Functional notes
// RULE1: normal request sampled low at instruction end
// RULE2: normal ranks below fast; masked by flag
// RULE3: normal entry saves next address plus 4
// RULE4: normal entry mode 10010, mask, vector 0x18
// RULE5: subtract return restores pc and status
// RULE6: prefetch abort tags; raised only at execute
// RULE7: single transfer abort keeps base write-back
// RULE8: swap abort leaves registers unchanged
// RULE9: block abort completes, blocks later overwrites
// RULE10: abort link plus four or eight
// RULE11: abort mode 10111, mask, vector 0x0c/0x10
// RULE12: software trap saves own address plus four
// RULE13: software trap mode 10011, mask, 0x08
// RULE14: undefined trap, control coprocessor transfers excepted
// RULE15: undefined entry plus 4, 11011, 0x04
// RULE16: move return restores status, next instruction
// RULE17: fixed priority reset, dabt, fiq, irq, pabt, und
// RULE18: dabt with fiq: abort entry then fiq
// RULE19: in reset, idle cycles on rising words
// RULE20: reset exit saves pc/status, svc, masks, 0x00
// RULE21: translation, alignment, cache, buffer off after reset
// RULE22: reset leaves 26-bit, early abort, little endian
// RULE23: fast entry plus 4, 10001, both masks, 0x1c
// RULE24: fast request delayed by synchroniser
// RULE25: entry actions all commit in one cycle
`timescale 1ns/10ps
`default_nettype none
module exc_entry_unit (
	input  wire logic           i_clock,
	input  wire logic           i_rst_b,
	input  wire logic           i_ce,
	input  wire logic           i_core_reset,   // core reset request, active high
	input  wire logic           i_irq_b,        // normal interrupt request, active low
	input  wire logic           i_fiq_b,        // fast interrupt request, active low
	input  wire logic           i_fetch_valid,
	input  wire logic           i_fetch_abort,
	input  wire logic           i_pipe_advance,
	input  wire logic           i_branch_flush,
	input  wire exc_pkg::instr_t i_instr,
	input  wire exc_pkg::dabt_t i_dabt,
	input  wire logic [31:0]    i_status_in,    // status word written by software
	input  wire logic           i_status_wr,
	output logic [31:0]         o_current_status_word,
	output logic [31:0]         o_saved_status_word,
	output logic [31:0]         o_link_value,
	output logic [4:0]          o_link_mode,    // bank the link/saved status belong to
	output logic                o_link_we,
	output logic                o_pc_load,
	output logic [31:0]         o_pc_target,
	output logic                o_idle,
	output logic [31:0]         o_idle_addr,
	output logic                o_base_wb_en,
	output logic                o_reg_wr_block,
	output logic                o_swap_cancel,
	output logic [9:0]          o_ctrl_cfg,     // mmu/align/cache/wb/prog/data/endian
	output logic                o_tlb_flush,
	output logic                o_cache_flush,
	output logic                o_early_abort
);
	logic fiq_s, irq_s, pf_tag;
	exc_pkg::seq_state_t st_r, st_nxt;
	logic [31:0] current_status_word_r, current_status_word_nxt, saved_status_word_r, saved_status_word_nxt, link_r, link_nxt;
	logic [31:0] pc_r, pc_nxt, idle_r, idle_nxt;
	logic [4:0]  lmode_r, lmode_nxt;
	logic        lwe_r, lwe_nxt, pcl_r, pcl_nxt, idle_en_r, idle_en_nxt;
	logic        wb_r, wb_nxt, blk_r, blk_nxt, swc_r, swc_nxt;
	logic        blk_hold_r, blk_hold_nxt, fiq_chain_r, fiq_chain_nxt;
	logic [9:0]  ctrl_r, ctrl_nxt;
	logic        tlbf_r, tlbf_nxt, cfl_r, cfl_nxt, early_r, early_nxt;
	exc_pkg::exc_kind_t kind;
	exc_pkg::entry_t    ent;
	logic               fiq_ok, irq_ok, undef_hit;
	logic [31:0]        link_base;

	// both requests pass two synchronising flops before use
	exc_sync u_fiq_sync (
		.i_clock (i_clock),
		.i_rst_b (i_rst_b),
		.i_ce    (i_ce),
		.i_async (i_fiq_b),
		.o_sync  (fiq_s)
	); // RULE24
	exc_sync u_irq_sync (
		.i_clock (i_clock),
		.i_rst_b (i_rst_b),
		.i_ce    (i_ce),
		.i_async (i_irq_b),
		.o_sync  (irq_s)
	);

	// prefetch abort marks travel with the instruction
	exc_prefetch_tag u_ptag (
		.i_clock       (i_clock),
		.i_rst_b       (i_rst_b),
		.i_ce          (i_ce),
		.i_fetch_valid (i_fetch_valid),
		.i_fetch_abort (i_fetch_abort),
		.i_advance     (i_pipe_advance),
		.i_flush       (i_branch_flush),
		.o_head_tag    (pf_tag)
	);

	// arbitration among pending exceptions; all but dabt and fiq wait for instruction end
	always_comb begin
		fiq_ok    = !fiq_s && !current_status_word_r[exc_pkg::BIT_F];
		irq_ok    = !irq_s && !current_status_word_r[exc_pkg::BIT_I]; // RULE1 RULE2
		undef_hit = i_instr.undef && !i_instr.cp_is_ctrl; // RULE14
		kind      = exc_pkg::EXC_NONE;
		if (i_dabt.d_abort)
			kind = exc_pkg::EXC_DABT; // RULE17
		else if (fiq_ok)
			kind = exc_pkg::EXC_FIQ;
		else if (i_instr.done && irq_ok)
			kind = exc_pkg::EXC_IRQ; // RULE2
		else if (i_instr.done && (i_instr.pf_abort || pf_tag))
			kind = exc_pkg::EXC_PABT; // RULE6
		else if (i_instr.done && undef_hit)
			kind = exc_pkg::EXC_UND;
		else if (i_instr.done && i_instr.swt)
			kind = exc_pkg::EXC_SWT;
	end

	// entry parameters per kind
	always_comb begin
		ent       = '{mode: exc_pkg::MODE_SVC, set_i: 1'b1, set_f: 1'b0,
			vector: exc_pkg::VEC_RESET, link_ofs: exc_pkg::OFS_4};
		link_base = i_instr.addr;
		unique case (kind)
			exc_pkg::EXC_FIQ: begin
				ent.mode = exc_pkg::MODE_FIQ; // RULE23
				ent.set_f = 1'b1;
				ent.vector = exc_pkg::VEC_FIQ;
				link_base = i_instr.next_addr;
			end
			exc_pkg::EXC_IRQ: begin
				ent.mode = exc_pkg::MODE_IRQ; // RULE4
				ent.vector = exc_pkg::VEC_IRQ;
				link_base = i_instr.next_addr; // RULE3
			end
			exc_pkg::EXC_DABT: begin
				ent.mode = exc_pkg::MODE_ABT; // RULE11
				ent.vector = exc_pkg::VEC_DABT;
				ent.link_ofs = exc_pkg::OFS_8; // RULE10
			end
			exc_pkg::EXC_PABT: begin
				ent.mode = exc_pkg::MODE_ABT; // RULE11
				ent.vector = exc_pkg::VEC_PABT; // RULE10
			end
			exc_pkg::EXC_UND: begin
				ent.mode = exc_pkg::MODE_UND; // RULE15
				ent.vector = exc_pkg::VEC_UND;
			end
			exc_pkg::EXC_SWT: begin
				ent.mode = exc_pkg::MODE_SVC; // RULE13
				ent.vector = exc_pkg::VEC_SWT; // RULE12
			end
			exc_pkg::EXC_NONE, exc_pkg::EXC_RST: begin
				ent.set_f = 1'b0;
			end
		endcase
	end

	// sequencer next state and all entry side effects, committed together
	always_comb begin
		st_nxt = st_r;
		current_status_word_nxt = current_status_word_r;
		saved_status_word_nxt = saved_status_word_r;
		link_nxt = link_r;
		lmode_nxt = lmode_r;
		pc_nxt = pc_r;
		idle_nxt = idle_r;
		lwe_nxt = 1'b0;
		pcl_nxt = 1'b0;
		idle_en_nxt = 1'b0;
		wb_nxt = 1'b0;
		swc_nxt = 1'b0;
		blk_hold_nxt = blk_hold_r;
		blk_nxt = blk_hold_r;
		fiq_chain_nxt = 1'b0;
		ctrl_nxt = ctrl_r;
		tlbf_nxt = 1'b0;
		cfl_nxt = 1'b0;
		early_nxt = early_r;
		if (i_ce) begin
			if (i_core_reset) begin
				st_nxt = exc_pkg::ST_RESET;
				idle_en_nxt = 1'b1; // RULE19
				idle_nxt = idle_r + exc_pkg::WORD_STEP;
				blk_hold_nxt = 1'b0;
				blk_nxt = 1'b0;
				ctrl_nxt = exc_pkg::CTRL_RST; // RULE21 RULE22
				tlbf_nxt = 1'b1; // RULE21
				cfl_nxt = 1'b1;
				early_nxt = 1'b1; // RULE22
			end else begin
				unique case (st_r)
					exc_pkg::ST_RESET: st_nxt = exc_pkg::ST_EXIT;
					exc_pkg::ST_EXIT: begin
						// save undefined pc and status, enter supervisor
						link_nxt = pc_r; // RULE20
						saved_status_word_nxt = current_status_word_r;
						lmode_nxt = exc_pkg::MODE_SVC;
						lwe_nxt = 1'b1;
						current_status_word_nxt = {current_status_word_r[31:8], 2'b11, current_status_word_r[5], exc_pkg::MODE_SVC};
						pc_nxt = exc_pkg::VEC_RESET;
						pcl_nxt = 1'b1;
						st_nxt = exc_pkg::ST_RUN;
					end
					exc_pkg::ST_RUN, exc_pkg::ST_ENTRY: begin
						st_nxt = exc_pkg::ST_RUN;
						if (i_dabt.d_abort) begin
							wb_nxt = i_dabt.wb_en && !i_dabt.is_swap; // RULE7 RULE9
							swc_nxt = i_dabt.is_swap; // RULE8
							blk_hold_nxt = i_dabt.is_block; // RULE9
							blk_nxt = i_dabt.is_block || i_dabt.is_swap;
							fiq_chain_nxt = fiq_ok; // RULE18
						end
						if (i_instr.done)
							blk_hold_nxt = 1'b0;
						if (fiq_chain_r && !current_status_word_r[exc_pkg::BIT_F]) begin
							// chained fast entry right after abort entry
							link_nxt = pc_r + exc_pkg::OFS_4; // RULE18
							saved_status_word_nxt = current_status_word_r;
							lmode_nxt = exc_pkg::MODE_FIQ;
							lwe_nxt = 1'b1;
							current_status_word_nxt = {current_status_word_r[31:8], 2'b11, current_status_word_r[5], exc_pkg::MODE_FIQ};
							pc_nxt = exc_pkg::VEC_FIQ;
							pcl_nxt = 1'b1;
							st_nxt = exc_pkg::ST_ENTRY;
						end else if (kind != exc_pkg::EXC_NONE) begin
							link_nxt = link_base + ent.link_ofs; // RULE25
							saved_status_word_nxt = current_status_word_r;
							lmode_nxt = ent.mode;
							lwe_nxt = 1'b1;
							current_status_word_nxt = {current_status_word_r[31:8], 1'b1, current_status_word_r[6] | ent.set_f,
								current_status_word_r[5], ent.mode};
							pc_nxt = ent.vector;
							pcl_nxt = 1'b1;
							st_nxt = exc_pkg::ST_ENTRY;
						end else if (i_instr.done && i_instr.ret_flag_setting_subtract) begin
							pc_nxt = i_instr.ret_lr - i_instr.ret_imm; // RULE5
							current_status_word_nxt = saved_status_word_r;
							pcl_nxt = 1'b1;
						end else if (i_instr.done && i_instr.ret_flag_setting_move) begin
							pc_nxt = i_instr.ret_lr; // RULE16
							current_status_word_nxt = saved_status_word_r;
							pcl_nxt = 1'b1;
						end else if (i_status_wr && current_status_word_r[4:0] != exc_pkg::MODE_USR) begin
							current_status_word_nxt = i_status_in; // RULE2
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r <= exc_pkg::ST_RESET;
			current_status_word_r <= exc_pkg::STATUS_RST;
			saved_status_word_r <= '0;
			link_r <= '0;
			lmode_r <= exc_pkg::MODE_SVC;
			pc_r <= '0;
			idle_r <= '0;
			lwe_r <= 1'b0;
			pcl_r <= 1'b0;
			idle_en_r <= 1'b0;
			wb_r <= 1'b0;
			blk_r <= 1'b0;
			swc_r <= 1'b0;
			blk_hold_r <= 1'b0;
			fiq_chain_r <= 1'b0;
			ctrl_r <= exc_pkg::CTRL_RST;
			tlbf_r <= 1'b0;
			cfl_r <= 1'b0;
			early_r <= 1'b1;
		end else begin
			st_r <= st_nxt;
			current_status_word_r <= current_status_word_nxt;
			saved_status_word_r <= saved_status_word_nxt;
			link_r <= link_nxt;
			lmode_r <= lmode_nxt;
			pc_r <= pc_nxt;
			idle_r <= idle_nxt;
			lwe_r <= lwe_nxt;
			pcl_r <= pcl_nxt;
			idle_en_r <= idle_en_nxt;
			wb_r <= wb_nxt;
			blk_r <= blk_nxt;
			swc_r <= swc_nxt;
			blk_hold_r <= blk_hold_nxt;
			fiq_chain_r <= fiq_chain_nxt;
			ctrl_r <= ctrl_nxt;
			tlbf_r <= tlbf_nxt;
			cfl_r <= cfl_nxt;
			early_r <= early_nxt;
		end
	end

	// outputs straight from flops
	assign o_current_status_word = current_status_word_r;
	assign o_saved_status_word = saved_status_word_r;
	assign o_link_value = link_r;
	assign o_link_mode = lmode_r;
	assign o_link_we = lwe_r;
	assign o_pc_load = pcl_r;
	assign o_pc_target = pc_r;
	assign o_idle = idle_en_r;
	assign o_idle_addr = idle_r;
	assign o_base_wb_en = wb_r;
	assign o_reg_wr_block = blk_r;
	assign o_swap_cancel = swc_r;
	assign o_ctrl_cfg = ctrl_r;
	assign o_tlb_flush = tlbf_r;
	assign o_cache_flush = cfl_r;
	assign o_early_abort = early_r;

	// checks
	property p_irq_entry;
		@(posedge i_clock) disable iff (!i_rst_b)
		(i_ce && !i_core_reset && st_r == exc_pkg::ST_RUN && !fiq_chain_r
			&& kind == exc_pkg::EXC_IRQ)
		|=> (pc_r == exc_pkg::VEC_IRQ && current_status_word_r[4:0] == exc_pkg::MODE_IRQ
			&& current_status_word_r[exc_pkg::BIT_I] && o_link_we);
	endproperty
	a_irq_entry: assert property (p_irq_entry) else $error("irq entry wrong"); // RULE4
	property p_irq_masked;
		@(posedge i_clock) disable iff (!i_rst_b)
		current_status_word_r[exc_pkg::BIT_I] |-> kind != exc_pkg::EXC_IRQ;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("masked irq taken"); // RULE2
	property p_dabt_first;
		@(posedge i_clock) disable iff (!i_rst_b)
		i_dabt.d_abort |-> kind == exc_pkg::EXC_DABT;
	endproperty
	a_dabt_first: assert property (p_dabt_first) else $error("dabt not first"); // RULE17
	property p_dabt_link;
		@(posedge i_clock) disable iff (!i_rst_b)
		(i_ce && !i_core_reset && st_r == exc_pkg::ST_RUN && !fiq_chain_r && i_dabt.d_abort)
		|=> (link_r == $past(i_instr.addr) + exc_pkg::OFS_8
			&& pc_r == exc_pkg::VEC_DABT && current_status_word_r[4:0] == exc_pkg::MODE_ABT);
	endproperty
	a_dabt_link: assert property (p_dabt_link) else $error("dabt link wrong"); // RULE10
	property p_chain;
		@(posedge i_clock) disable iff (!i_rst_b)
		(fiq_chain_r && i_ce && !i_core_reset && !current_status_word_r[exc_pkg::BIT_F])
		|=> (pc_r == exc_pkg::VEC_FIQ && current_status_word_r[4:0] == exc_pkg::MODE_FIQ && saved_status_word_r[4:0] == exc_pkg::MODE_ABT);
	endproperty
	a_chain: assert property (p_chain) else $error("fiq chain missing"); // RULE18
	property p_swap;
		@(posedge i_clock) disable iff (!i_rst_b)
		(o_swap_cancel) |-> (!o_base_wb_en && o_reg_wr_block);
	endproperty
	a_swap: assert property (p_swap) else $error("swap not cancelled"); // RULE8
	property p_reset_exit;
		@(posedge i_clock) disable iff (!i_rst_b)
		(st_r == exc_pkg::ST_EXIT && i_ce && !i_core_reset)
		|=> (pc_r == exc_pkg::VEC_RESET && current_status_word_r[7:6] == 2'b11
			&& current_status_word_r[4:0] == exc_pkg::MODE_SVC && o_pc_load);
	endproperty
	a_reset_exit: assert property (p_reset_exit) else $error("reset exit wrong"); // RULE20
	property p_idle;
		@(posedge i_clock) disable iff (!i_rst_b)
		(i_core_reset && i_ce) ##1 (i_core_reset && i_ce)
		|=> (o_idle && o_idle_addr == $past(o_idle_addr) + exc_pkg::WORD_STEP);
	endproperty
	a_idle: assert property (p_idle) else $error("idle addr not rising"); // RULE19
	property p_cfg;
		@(posedge i_clock) disable iff (!i_rst_b)
		(i_core_reset && i_ce) |=> (o_ctrl_cfg == exc_pkg::CTRL_RST && o_tlb_flush && o_early_abort);
	endproperty
	a_cfg: assert property (p_cfg) else $error("reset config wrong"); // RULE21
	c_irq: cover property (@(posedge i_clock) kind == exc_pkg::EXC_IRQ);
	c_chain: cover property (@(posedge i_clock) fiq_chain_r);
	c_swt: cover property (@(posedge i_clock) kind == exc_pkg::EXC_SWT);
endmodule // exc_entry_unit
`default_nettype wire

//--- src/exc_pkg.sv
// package: constants and types for the exception entry unit
package exc_pkg;
	localparam logic [4:0]  MODE_USR  = 5'h10;
	localparam logic [4:0]  MODE_FIQ  = 5'h11; // 10001
	localparam logic [4:0]  MODE_IRQ  = 5'h12; // 10010
	localparam logic [4:0]  MODE_SVC  = 5'h13; // 10011
	localparam logic [4:0]  MODE_ABT  = 5'h17; // 10111
	localparam logic [4:0]  MODE_UND  = 5'h1b; // 11011
	localparam logic [31:0] VEC_RESET = 32'h0000_0000;
	localparam logic [31:0] VEC_UND   = 32'h0000_0004;
	localparam logic [31:0] VEC_SWT   = 32'h0000_0008;
	localparam logic [31:0] VEC_PABT  = 32'h0000_000c;
	localparam logic [31:0] VEC_DABT  = 32'h0000_0010;
	localparam logic [31:0] VEC_IRQ   = 32'h0000_0018;
	localparam logic [31:0] VEC_FIQ   = 32'h0000_001c;
	localparam logic [31:0] OFS_4     = 32'h0000_0004;
	localparam logic [31:0] OFS_8     = 32'h0000_0008;
	localparam logic [31:0] WORD_STEP = 32'h0000_0004;
	localparam int          BIT_I     = 7;
	localparam int          BIT_F     = 6;
	localparam logic [31:0] STATUS_RST = 32'h0000_00d3; // svc, both masks set
	localparam logic [9:0]  CTRL_RST  = 10'h000; // mmu, align, cache, wb off, 26-bit, little
	// exception kind, priority order is encoded in the arbiter
	typedef enum logic [2:0] {
		EXC_NONE = 3'h0,
		EXC_RST  = 3'h1,
		EXC_DABT = 3'h2,
		EXC_FIQ  = 3'h3,
		EXC_IRQ  = 3'h4,
		EXC_PABT = 3'h5,
		EXC_UND  = 3'h6,
		EXC_SWT  = 3'h7
	} exc_kind_t;
	// sequencer states, gray along reset -> exit -> run -> entry
	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_EXIT  = 2'b01,
		ST_RUN   = 2'b11,
		ST_ENTRY = 2'b10
	} seq_state_t;
	// one entry action bundle
	typedef struct packed {
		logic [4:0]  mode;
		logic        set_i;
		logic        set_f;
		logic [31:0] vector;
		logic [31:0] link_ofs;
	} entry_t;
	// end-of-instruction report from the pipeline
	typedef struct packed {
		logic        done;       // instruction completes this cycle
		logic [31:0] addr;       // its address
		logic [31:0] next_addr;  // address of next instruction
		logic        pf_abort;   // instruction was tagged by a prefetch abort
		logic        undef;      // undecodable / unsupported coprocessor op
		logic        cp_is_ctrl; // coprocessor reg transfer to control coprocessor
		logic        swt;        // software trap instruction
		logic        ret_flag_setting_subtract;   // flag-setting subtract lr-imm into pc
		logic        ret_flag_setting_move;   // flag-setting move lr into pc
		logic [31:0] ret_lr;     // link value used by return
		logic [31:0] ret_imm;    // immediate of the subtract
	} instr_t;
	// data abort context reported by the load/store unit
	typedef struct packed {
		logic d_abort;  // abort on data access
		logic is_swap;  // atomic swap
		logic is_block; // block transfer
		logic wb_en;    // instruction requests base write-back
	} dabt_t;
endpackage : exc_pkg

//--- src/exc_prefetch_tag.sv
// prefetch-abort tag pipe: carries the invalid mark alongside fetched words
`timescale 1ns/10ps
`default_nettype none
module exc_prefetch_tag (
	input  wire logic i_clock,
	input  wire logic i_rst_b,
	input  wire logic i_ce,
	input  wire logic i_fetch_valid,
	input  wire logic i_fetch_abort,
	input  wire logic i_advance,
	input  wire logic i_flush,
	output logic      o_head_tag
);
	logic [1:0] tag_r, tag_nxt;
	// two-deep pipe, a taken branch flush drops tags
	always_comb begin
		tag_nxt = tag_r;
		if (i_ce) begin
			if (i_flush)
				tag_nxt = 2'b00; // RULE6
			else if (i_advance)
				tag_nxt = {tag_r[0], i_fetch_valid & i_fetch_abort};
		end
	end
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b)
			tag_r <= 2'b00;
		else
			tag_r <= tag_nxt;
	end
	assign o_head_tag = tag_r[1];
endmodule // exc_prefetch_tag
`default_nettype wire

//--- src/exc_sync.sv
// two-stage synchroniser for one request line
`timescale 1ns/10ps
`default_nettype none
module exc_sync (
	input  wire logic i_clock,
	input  wire logic i_rst_b,
	input  wire logic i_ce,
	input  wire logic i_async,
	output logic      o_sync
);
	logic s1_r, s1_nxt, s2_r, s2_nxt;
	// shift the level through two flops, idle high
	always_comb begin
		s1_nxt = i_ce ? i_async : s1_r;
		s2_nxt = i_ce ? s1_r : s2_r;
	end
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
		end
	end
	assign o_sync = s2_r;
endmodule // exc_sync
`default_nettype wire

//--- tb/exc_entry_unit_tb.sv
// self-checking bench for the exception entry unit
`timescale 1ns/10ps
`default_nettype none
module exc_entry_unit_tb;
	// one captured fetch redirect with the state it left behind
	typedef struct packed {
		logic [31:0] pc;
		logic [31:0] st;
		logic [31:0] lk;
		logic [4:0]  lm;
		logic [31:0] sv;
		logic        we;
	} redirect_t;
	localparam logic [5:0] PF = 6'h20;
	localparam logic [5:0] UN = 6'h10;
	localparam logic [5:0] CP = 6'h08;
	localparam logic [5:0] SW = 6'h04;
	localparam logic [5:0] RS = 6'h02;
	localparam logic [5:0] RM = 6'h01;
	logic            i_clock    = 1'b0;
	logic            i_rst_b    = 1'b0;
	logic            core_reset = 1'b0;
	logic            irq_req    = 1'b0;
	logic            fiq_req    = 1'b0;
	logic            status_wr  = 1'b0;
	logic [31:0]     status_in  = 32'h0;
	exc_pkg::instr_t instr      = '0;
	exc_pkg::dabt_t  dabt       = '0;
	logic            fetch_abort = 1'b0;
	logic            advance    = 1'b0;
	logic            flush      = 1'b0;
	logic            irq_b, fiq_b, pc_load, idle, wb_en, wr_block, swap_cancel;
	logic            tlb_fl, cache_fl, early, link_we;
	logic [31:0]     cur_st, sav_st, lnk, pc_tgt, idle_addr;
	logic [4:0]      lnk_mode;
	logic [9:0]      ctrl;
	logic [4:0]      seen = '0; // cache, tlb, swap, block, write-back
	redirect_t       evq[$];
	int              mismatches = 0;
	int              checks = 0;

	irq_mmu_model irq_mmu_model_i (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_irq_req(irq_req),
		.i_fiq_req(fiq_req),
		.o_irq_b(irq_b),
		.o_fiq_b(fiq_b)
	);
	// a fetched word counts as valid whenever the pipe advances
	exc_entry_unit exc_entry_unit_i (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_ce(1'b1),
		.i_core_reset(core_reset),
		.i_irq_b(irq_b),
		.i_fiq_b(fiq_b),
		.i_fetch_valid(advance),
		.i_fetch_abort(fetch_abort),
		.i_pipe_advance(advance),
		.i_branch_flush(flush),
		.i_instr(instr),
		.i_dabt(dabt),
		.i_status_in(status_in),
		.i_status_wr(status_wr),
		.o_current_status_word(cur_st),
		.o_saved_status_word(sav_st),
		.o_link_value(lnk),
		.o_link_mode(lnk_mode),
		.o_link_we(link_we),
		.o_pc_load(pc_load),
		.o_pc_target(pc_tgt),
		.o_idle(idle),
		.o_idle_addr(idle_addr),
		.o_base_wb_en(wb_en),
		.o_reg_wr_block(wr_block),
		.o_swap_cancel(swap_cancel),
		.o_ctrl_cfg(ctrl),
		.o_tlb_flush(tlb_fl),
		.o_cache_flush(cache_fl),
		.o_early_abort(early)
	);

	initial forever #4 i_clock = ~i_clock;

	// capture every redirect and remember side pulses between checks
	always @(negedge i_clock) begin
		if (pc_load === 1'b1) evq.push_back('{pc_tgt, cur_st, lnk, lnk_mode, sav_st, link_we});
		seen = seen | {cache_fl, tlb_fl, swap_cancel, wr_block, wb_en};
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask

	task automatic expect_pc(input logic [31:0] vec, input logic [31:0] st,
			input logic [31:0] lk, input logic [31:0] sv, input logic full);
		redirect_t e;
		int        n;
		n = 0;
		while (evq.size() == 0 && n < 12) begin
			@(negedge i_clock);
			n++;
		end
		chk("redirect", 32'h1, 32'(evq.size() != 0));
		if (evq.size() != 0) begin
			e = evq.pop_front();
			chk("pc_target", vec, e.pc);
			chk("status", st, e.st);
			if (full) begin
				chk("link", lk, e.lk);
				chk("saved_status", sv, e.sv);
				chk("link_mode", 32'(st[4:0]), 32'(e.lm));
				chk("link_we", 32'h1, 32'(e.we));
			end
		end
	endtask

	task automatic expect_none();
		repeat (8) @(negedge i_clock);
		chk("redirect", 32'h0, 32'(evq.size()));
	endtask

	task automatic req(input logic irq, input logic fiq);
		@(posedge i_clock);
		irq_req <= irq;
		fiq_req <= fiq;
	endtask

	// privileged status write; also drops stale redirects
	task automatic wr_status(input logic [31:0] v);
		@(posedge i_clock);
		status_in <= v;
		status_wr <= 1'b1;
		@(posedge i_clock);
		status_wr <= 1'b0;
		evq.delete();
	endtask

	// one-cycle end-of-instruction report, next address is four on
	task automatic retire(input logic [31:0] a, input logic [5:0] f, input logic [31:0] lr);
		@(posedge i_clock);
		instr <= '{1'b1, a, a + 32'h4, f[5], f[4], f[3], f[2], f[1], f[0], lr, 32'h4};
		@(posedge i_clock);
		instr <= '{1'b0, a, a + 32'h4, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, lr, 32'h4};
	endtask

	task automatic s_reset_exit();
		expect_pc(exc_pkg::VEC_RESET, 32'hd3, 32'h0, 32'h0, 1'b0);
		chk("ctrl_cfg", 32'h0, 32'(ctrl));
		chk("early_abort", 32'h1, 32'(early));
	endtask

	task automatic s_irq();
		wr_status(32'h13);
		req(1'b1, 1'b0);
		repeat (4) @(posedge i_clock);
		retire(32'h100, 6'h0, 32'h0);
		expect_pc(exc_pkg::VEC_IRQ, 32'h92, 32'h108, 32'h13, 1'b1);
		req(1'b0, 1'b0);
		repeat (4) @(posedge i_clock);
		retire(32'h180, RS, 32'h108);
		expect_pc(32'h104, 32'h13, 32'h0, 32'h0, 1'b0);
	endtask

	task automatic s_irq_masked();
		wr_status(32'h93);
		req(1'b1, 1'b0);
		repeat (4) @(posedge i_clock);
		retire(32'h200, 6'h0, 32'h0);
		expect_none();
		req(1'b0, 1'b0);
		repeat (4) @(posedge i_clock);
	endtask

	task automatic s_fiq_first();
		wr_status(32'h13);
		req(1'b1, 1'b1);
		expect_pc(exc_pkg::VEC_FIQ, 32'hd1, 32'h0, 32'h13, 1'b0);
		retire(32'h300, 6'h0, 32'h0);
		expect_none();
		req(1'b0, 1'b0);
		repeat (4) @(posedge i_clock);
	endtask

	// data abort lands in the same cycle as the synchronised fast request
	task automatic s_dabt_fiq();
		wr_status(32'h13);
		retire(32'h400, 6'h0, 32'h0);
		seen = '0;
		req(1'b0, 1'b1);
		repeat (3) @(posedge i_clock);
		dabt <= '{1'b1, 1'b0, 1'b0, 1'b1};
		@(posedge i_clock);
		dabt <= '0;
		expect_pc(exc_pkg::VEC_DABT, 32'h97, 32'h408, 32'h13, 1'b1);
		expect_pc(exc_pkg::VEC_FIQ, 32'hd1, 32'h14, 32'h97, 1'b1);
		chk("base_wb", 32'h1, 32'(seen[0]));
		req(1'b0, 1'b0);
		repeat (4) @(posedge i_clock);
	endtask

	task automatic s_swap_block();
		wr_status(32'h13);
		retire(32'h500, 6'h0, 32'h0);
		seen = '0;
		@(posedge i_clock);
		dabt <= '{1'b1, 1'b1, 1'b0, 1'b0};
		@(posedge i_clock);
		dabt <= '0;
		expect_pc(exc_pkg::VEC_DABT, 32'h97, 32'h508, 32'h13, 1'b1);
		chk("swap_cancel", 32'h1, 32'(seen[2]));
		wr_status(32'h13);
		seen = '0;
		@(posedge i_clock);
		dabt <= '{1'b1, 1'b0, 1'b1, 1'b1};
		@(posedge i_clock);
		dabt <= '0;
		repeat (2) @(posedge i_clock);
		retire(32'h580, 6'h0, 32'h0);
		expect_pc(exc_pkg::VEC_DABT, 32'h97, 32'h0, 32'h0, 1'b0);
		// the block flag drops one cycle after the completing report
		repeat (2) @(negedge i_clock);
		chk("block_and_wb", 32'h3, 32'(seen[1:0]));
		chk("reg_wr_block", 32'h0, 32'(wr_block));
	endtask

	// aborted fetch word reaches the head and retires, then one is flushed early
	task automatic s_prefetch();
		wr_status(32'h13);
		@(posedge i_clock);
		fetch_abort <= 1'b1;
		advance <= 1'b1;
		@(posedge i_clock);
		fetch_abort <= 1'b0;
		@(posedge i_clock);
		advance <= 1'b0;
		retire(32'h600, 6'h0, 32'h0);
		expect_pc(exc_pkg::VEC_PABT, 32'h97, 32'h604, 32'h13, 1'b1);
		wr_status(32'h13);
		fetch_abort <= 1'b1;
		advance <= 1'b1;
		@(posedge i_clock);
		fetch_abort <= 1'b0;
		advance <= 1'b0;
		flush <= 1'b1;
		@(posedge i_clock);
		flush <= 1'b0;
		retire(32'h680, 6'h0, 32'h0);
		expect_none();
	endtask

	task automatic s_traps();
		wr_status(32'h13);
		retire(32'h700, PF, 32'h0);
		expect_pc(exc_pkg::VEC_PABT, 32'h97, 32'h704, 32'h13, 1'b1);
		wr_status(32'h13);
		retire(32'h800, SW, 32'h0);
		expect_pc(exc_pkg::VEC_SWT, 32'h93, 32'h804, 32'h13, 1'b1);
		wr_status(32'h13);
		retire(32'ha00, UN | CP, 32'h0);
		expect_none();
		retire(32'h900, UN, 32'h0);
		expect_pc(exc_pkg::VEC_UND, 32'h9b, 32'h904, 32'h13, 1'b1);
		retire(32'h980, RM, 32'h904);
		expect_pc(32'h904, 32'h13, 32'h0, 32'h0, 1'b0);
		req(1'b1, 1'b0);
		repeat (4) @(posedge i_clock);
		retire(32'hb00, PF, 32'h0);
		expect_pc(exc_pkg::VEC_IRQ, 32'h92, 32'hb08, 32'h13, 1'b1);
		req(1'b0, 1'b0);
	endtask

	task automatic s_core_reset();
		logic [31:0] a;
		seen = '0;
		@(posedge i_clock);
		core_reset <= 1'b1;
		repeat (3) @(negedge i_clock);
		a = idle_addr;
		@(negedge i_clock);
		chk("idle", 32'h1, 32'(idle));
		chk("idle_addr", a + 32'h4, idle_addr);
		chk("flushes", 32'h18, 32'(seen));
		evq.delete();
		@(posedge i_clock);
		core_reset <= 1'b0;
		expect_pc(exc_pkg::VEC_RESET, 32'hd3, 32'h0, 32'h0, 1'b0);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// watchdog well beyond the few hundred cycles the sequence needs
	initial begin
		#200000;
		mismatches++;
		finish_test();
	end

	initial begin
		repeat (12) @(posedge i_clock);
		i_rst_b <= 1'b1;
		s_reset_exit();
		s_irq();
		s_irq_masked();
		s_fiq_first();
		s_dabt_fiq();
		s_swap_block();
		s_prefetch();
		s_traps();
		s_core_reset();
		finish_test();
	end
endmodule // exc_entry_unit_tb
`default_nettype wire

//--- tb/irq_mmu_model.sv
// interrupt controller model driving the core's request pins
`timescale 1ns/10ps
`default_nettype none
module irq_mmu_model (
	input  wire logic i_clock,
	input  wire logic i_rst_b,
	input  wire logic i_irq_req,
	input  wire logic i_fiq_req,
	output logic      o_irq_b,
	output logic      o_fiq_b
);
	// requests leave the controller one clock after they are raised, active low
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_irq_b <= 1'b1;
			o_fiq_b <= 1'b1;
		end else begin
			o_irq_b <= ~i_irq_req;
			o_fiq_b <= ~i_fiq_req;
		end
	end
endmodule // irq_mmu_model
`default_nettype wire
